// >>> verilog/vsc_turn_on_ctrl.sv
// turn-on timing of a valley-switched offline converter
`timescale 1ns/1ps
module vsc_turn_on_ctrl
	import vsc_pkg::*;
#(
	parameter bit HIGH_FREQ = 1'b0,                  // selects 225 kHz limit
	parameter int STARTER_PERIOD = STARTER_CYC,      // starter period, cycles
	parameter int TRIG_DELAY = TRIG_DELAY_CYC,       // trigger to turn-on
	parameter int STROBE_AT = STROBE_CYC,            // strobe instant after off
	parameter int OFF_DELAY = OFF_DELAY_CYC,         // limit to turn-off
	parameter int BLANK_SHORT = BLANK_SHORT_CYC,     // short blanking, cycles
	parameter int BLANK_LONG = BLANK_LONG_CYC        // long blanking, cycles
) (
	input wire logic i_clk_sys,        // 25 MHz system clock
	input wire logic i_rst_n,          // async reset, active low
	input wire vsc_cmp_t i_cmp,        // raw comparator levels
	output logic o_gate,               // power switch on
	output logic o_reduced_charge,     // enable reduced_charge_current
	output logic o_starter_mode,       // fixed-frequency starter active
	output logic o_blank_long,         // long blanking length selected
	output logic o_fault               // auto-restart in progress
);

	////////////////////////////////////////////////////////////////////////////
	// widths and constants at counter width

	localparam int OSC_PERIOD = HIGH_FREQ ? OSC_HIGH_CYC : OSC_LOW_CYC;
	// counters share one width, sized for the longest of the long blanking, starter and oscillator counts
	localparam int CNT_TOP = (BLANK_LONG > STARTER_PERIOD) ? BLANK_LONG : STARTER_PERIOD;
	localparam int CNT_MAX = (CNT_TOP > OSC_PERIOD) ? CNT_TOP : OSC_PERIOD;
	localparam int CW = $clog2(CNT_MAX + 1);
	localparam logic [CW-1:0] C_ZERO = '0;
	localparam logic [CW-1:0] C_ONE = CW'(1);
	localparam logic [CW-1:0] C_OSC_LAST = CW'(OSC_PERIOD - 1);
	localparam logic [CW-1:0] C_STARTER_LAST = CW'(STARTER_PERIOD - 1);
	localparam logic [CW-1:0] C_TRIG_DELAY = CW'(TRIG_DELAY);
	localparam logic [CW-1:0] C_OFF_DELAY = CW'(OFF_DELAY);
	localparam logic [CW-1:0] C_STROBE_AT = CW'(STROBE_AT);
	localparam logic [CW-1:0] C_BLANK_SHORT = CW'(BLANK_SHORT);
	localparam logic [CW-1:0] C_BLANK_LONG = CW'(BLANK_LONG);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisation and edge detection

	vsc_cmp_t cmp;
	vsc_cmp_t cmp_prev;
	logic arm_rise;
	logic trig_rise;

	vsc_sync #(
		.WIDTH($bits(vsc_cmp_t))
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_cmp),
		.o_sync(cmp)
	);

	// previous synchronised value, for edges only
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp_prev <= '0;
		end else begin
			cmp_prev <= cmp;
		end
	end

	// rising above arming, falling below trigger
	assign arm_rise = cmp.arm_above & ~cmp_prev.arm_above;
	assign trig_rise = cmp.trig_below & ~cmp_prev.trig_below;

	////////////////////////////////////////////////////////////////////////////
	// state

	vsc_run_t run, next_run;
	vsc_phase_t phase, next_phase;
	logic [CW-1:0] osc_cnt, next_osc_cnt;
	logic [CW-1:0] blank_cnt, next_blank_cnt;
	logic [CW-1:0] starter_cnt, next_starter_cnt;
	logic [CW-1:0] phase_cnt, next_phase_cnt;
	logic osc_done, next_osc_done;
	logic armed, next_armed;
	logic arm_seen, next_arm_seen;
	logic starter, next_starter;
	logic blank_long, next_blank_long;
	logic restart_seen, next_restart_seen;
	logic gate, next_gate;
	logic charge, next_charge;
	logic fault, next_fault;

	logic blanking;
	logic turn_on;
	logic turn_off;

	assign blanking = (blank_cnt != C_ZERO);

	////////////////////////////////////////////////////////////////////////////
	// next-state logic for the whole controller
	always_comb begin
		next_run = run;
		next_phase = phase;
		next_osc_cnt = osc_cnt;
		next_blank_cnt = blank_cnt;
		next_starter_cnt = starter_cnt;
		next_phase_cnt = phase_cnt;
		next_osc_done = osc_done;
		next_armed = armed;
		next_arm_seen = arm_seen;
		next_starter = starter;
		next_blank_long = blank_long;
		next_restart_seen = restart_seen;
		next_gate = gate;
		turn_on = 1'b0;
		turn_off = 1'b0;

		// limit oscillator, restarted at each turn-on, stops at cycle end
		if (!osc_done) begin
			if (osc_cnt == C_OSC_LAST) begin
				next_osc_done = 1'b1;
				// no arm by cycle end, fall back
				if (phase == PH_OFF && !arm_seen) begin
					next_starter = 1'b1;
				end
			end else begin
				next_osc_cnt = osc_cnt + C_ONE;
			end
		end

		// starter period counter saturates until next turn-on
		if (starter_cnt != C_STARTER_LAST) begin
			next_starter_cnt = starter_cnt + C_ONE;
		end

		// blanking window runs its chosen length
		if (blanking) begin
			// strobe sample picks the blanking length
			if (blank_cnt == C_STROBE_AT) begin
				next_blank_long = ~cmp.strobe_hi;
			end
			if (blank_cnt >= (blank_long ? C_BLANK_LONG : C_BLANK_SHORT)) begin
				next_blank_cnt = C_ZERO;
			end else begin
				next_blank_cnt = blank_cnt + C_ONE;
			end
		end

		unique case (run)
			RS_WAIT_SUPPLY: begin
				if (cmp.supply_on) begin
					next_run = RS_RUN;
				end
			end
			RS_RUN: begin
				unique case (phase)
					PH_OFF: begin
						if (!blanking) begin
							if (arm_rise) begin
								next_armed = 1'b1;
								next_arm_seen = 1'b1;
								next_starter = 1'b0;
							end
							if (trig_rise && armed) begin
								next_armed = 1'b0;
								// limit oscillator gate covers late window end
								if (osc_done && !starter) begin
									next_phase = PH_TRIG_WAIT;
									next_phase_cnt = C_TRIG_DELAY;
								end
							end
							if (starter && !arm_rise && starter_cnt == C_STARTER_LAST) begin
								turn_on = 1'b1;
							end
						end
					end
					PH_TRIG_WAIT: begin
						// fixed delay aims at the valley
						if (phase_cnt == C_ZERO) begin
							turn_on = 1'b1;
						end else begin
							next_phase_cnt = phase_cnt - C_ONE;
						end
					end
					PH_ON: begin
						// current limit starts the off delay
						if (cmp.current_limit) begin
							next_phase = PH_OFF_DELAY;
							next_phase_cnt = C_OFF_DELAY;
						end
					end
					PH_OFF_DELAY: begin
						if (phase_cnt == C_ZERO) begin
							turn_off = 1'b1;
						end else begin
							next_phase_cnt = phase_cnt - C_ONE;
						end
					end
				endcase

				// oscillator period sets the maximum rate
				if (turn_on) begin
					next_phase = PH_ON;
					next_gate = 1'b1;
					next_osc_cnt = C_ZERO;
					next_osc_done = 1'b0;
					next_starter_cnt = C_ZERO;
					next_armed = 1'b0;
				end
				if (turn_off) begin
					next_phase = PH_OFF;
					next_gate = 1'b0;
					next_blank_cnt = C_ONE;
					next_arm_seen = 1'b0;
				end

				// any protection stops switching at once
				if (cmp.protect_trip) begin
					next_run = RS_FAULT;
					next_phase = PH_OFF;
					next_gate = 1'b0;
					next_armed = 1'b0;
					next_restart_seen = 1'b0;
				end
			end
			RS_FAULT: begin
				// remember the fall below restart threshold
				if (cmp.supply_low) begin
					next_restart_seen = 1'b1;
				end
				// supply back at on threshold, new start-up
				if (restart_seen && cmp.supply_on) begin
					next_run = RS_RUN;
					next_restart_seen = 1'b0;
					next_phase = PH_OFF;
					next_starter = 1'b1;
					next_starter_cnt = C_ZERO;
					next_blank_long = 1'b1;
					next_blank_cnt = C_ZERO;
					next_arm_seen = 1'b0;
					next_osc_done = 1'b1;
				end
			end
			default: begin
				next_run = RS_WAIT_SUPPLY;
			end
		endcase

		// reduced charging only while input is high enough
		next_charge = (next_run == RS_FAULT) && next_restart_seen && cmp.input_ok;
		// registered copy of the restart state, so the pin needs no decode
		next_fault = (next_run == RS_FAULT);
	end

	////////////////////////////////////////////////////////////////////////////
	// registers; start-up begins in starter mode with long blanking
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run <= RS_WAIT_SUPPLY;
			phase <= PH_OFF;
			osc_cnt <= '0;
			blank_cnt <= '0;
			starter_cnt <= '0;
			phase_cnt <= '0;
			osc_done <= 1'b1;
			armed <= 1'b0;
			arm_seen <= 1'b0;
			starter <= 1'b1;
			blank_long <= 1'b1;
			restart_seen <= 1'b0;
			gate <= 1'b0;
			charge <= 1'b0;
			fault <= 1'b0;
		end else begin
			run <= next_run;
			phase <= next_phase;
			osc_cnt <= next_osc_cnt;
			blank_cnt <= next_blank_cnt;
			starter_cnt <= next_starter_cnt;
			phase_cnt <= next_phase_cnt;
			osc_done <= next_osc_done;
			armed <= next_armed;
			arm_seen <= next_arm_seen;
			starter <= next_starter;
			blank_long <= next_blank_long;
			restart_seen <= next_restart_seen;
			gate <= next_gate;
			charge <= next_charge;
			fault <= next_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, each straight from a flip-flop

	assign o_gate = gate;
	assign o_reduced_charge = charge;
	assign o_starter_mode = starter;
	assign o_blank_long = blank_long;
	assign o_fault = fault;

endmodule

// >>> verilog/vsc_pkg.sv
// constants, types and carriers for the valley-switched turn-on control
package vsc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock
	localparam real CLK_HZ = 25.0e6;

	////////////////////////////////////////////////////////////////////////////
	// frequency-limit oscillator, two product variants
	localparam real F_OSC_LOW_HZ = 136.0e3;
	localparam real F_OSC_HIGH_HZ = 225.0e3;
	// a maximum rate means a least period, so round the period up
	localparam int OSC_LOW_CYC = int'($ceil(CLK_HZ / F_OSC_LOW_HZ));
	localparam int OSC_HIGH_CYC = int'($ceil(CLK_HZ / F_OSC_HIGH_HZ));

	////////////////////////////////////////////////////////////////////////////
	// blanking lengths, in the printed unit (seconds)
	localparam real T_BLANK_SHORT_S = 2.5;
	localparam real T_BLANK_LONG_S = 6.3;
	localparam int BLANK_SHORT_CYC = int'($ceil(T_BLANK_SHORT_S * CLK_HZ));
	localparam int BLANK_LONG_CYC = int'($ceil(T_BLANK_LONG_S * CLK_HZ));

	////////////////////////////////////////////////////////////////////////////
	// values with no printed figure, plain defaults for the top parameters
	localparam real F_STARTER_HZ = 20.0e3;
	localparam real T_TRIG_DELAY_NS = 200.0;
	localparam real T_STROBE_NS = 1000.0;
	localparam real T_OFF_DELAY_NS = 80.0;
	localparam int STARTER_CYC = int'($ceil(CLK_HZ / F_STARTER_HZ));
	localparam int TRIG_DELAY_CYC = int'($ceil(T_TRIG_DELAY_NS * CLK_HZ / 1.0e9));
	localparam int STROBE_CYC = int'($ceil(T_STROBE_NS * CLK_HZ / 1.0e9));
	localparam int OFF_DELAY_CYC = int'($ceil(T_OFF_DELAY_NS * CLK_HZ / 1.0e9));

	// synchroniser depth
	localparam int SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////////////////
	// supervisory state of the controller
	typedef enum logic [1:0] {
		RS_WAIT_SUPPLY,
		RS_RUN,
		RS_FAULT
	} vsc_run_t;

	// switching phase inside one cycle
	typedef enum logic [1:0] {
		PH_OFF,
		PH_TRIG_WAIT,
		PH_ON,
		PH_OFF_DELAY
	} vsc_phase_t;

	// analog comparator outputs, all asynchronous to the clock
	typedef struct packed {
		logic arm_above;      // demag_detect_input above arming_threshold
		logic trig_below;     // demag_detect_input below trigger_threshold
		logic strobe_hi;      // demag_detect_input above 1 V
		logic supply_on;      // supply at or above supply_on_threshold
		logic supply_low;     // supply below supply_restart_threshold
		logic input_ok;       // bulk input above start threshold
		logic protect_trip;   // any protection tripped
		logic current_limit;  // switch current reached its limit
	} vsc_cmp_t;

endpackage

// >>> verilog/vsc_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module vsc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk_sys,            // system clock
	input wire logic i_rst_n,              // async reset, active low
	input wire logic [WIDTH-1:0] i_async,  // levels from outside the domain
	output logic [WIDTH-1:0] o_sync        // levels safe to use
);
	logic [WIDTH-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= '0;
			o_sync <= '0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// >>> tb/vsc_turn_on_ctrl_asserts.sv
// port checker for the valley-switched turn-on control
`timescale 1ns/1ps
module vsc_turn_on_ctrl_asserts
	import vsc_pkg::*;
#(
	parameter bit HIGH_FREQ = 1'b0,
	parameter int STARTER_PERIOD = STARTER_CYC,
	parameter int TRIG_DELAY = TRIG_DELAY_CYC,
	parameter int BLANK_SHORT = BLANK_SHORT_CYC
) (
	input wire logic i_clk_sys, // clock
	input wire logic i_rst_n, // reset
	input wire vsc_cmp_t i_cmp, // comparators
	input wire logic o_gate, // switch
	input wire logic o_reduced_charge, // slow charge
	input wire logic o_starter_mode, // starter
	input wire logic o_blank_long, // long blank
	input wire logic o_fault // restart
);
	localparam int OSC = HIGH_FREQ ? OSC_HIGH_CYC : OSC_LOW_CYC;
	int on_gap;
	int off_gap;
	int trig_age;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////////
	// ages since turn-on, turn-off and pin trigger; saturation keeps them quiet
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			on_gap <= 9999;
			off_gap <= 9999;
			trig_age <= 9999;
		end else begin
			on_gap <= $rose(o_gate) ? 0 : on_gap + int'(on_gap < 9999);
			off_gap <= $fell(o_gate) ? 0 : off_gap + int'(off_gap < 9999);
			trig_age <= $rose(i_cmp.trig_below) ? 0 : trig_age + int'(trig_age < 9999);
		end
	end
	sequence trip_held;
		i_cmp.protect_trip [*5];
	endsequence
	sequence turn_on;
		$rose(o_gate);
	endsequence
	trip_stop_a: assert property (trip_held |-> !o_gate)
		else $error("gate on during trip");
	fault_gate_off_a: assert property (o_fault |-> !o_gate)
		else $error("gate on in restart");
	charge_in_fault_a: assert property (o_reduced_charge |-> o_fault)
		else $error("slow charge outside restart");
	charge_input_a: assert property (!i_cmp.input_ok [*6] |-> !o_reduced_charge)
		else $error("slow charge without input");
	restart_state_a: assert property ($fell(o_fault) |->
		o_starter_mode && o_blank_long && !o_reduced_charge)
		else $error("restart state wrong");
	osc_spacing_a: assert property (turn_on |-> on_gap >= OSC - 1)
		else $error("turn-ons closer than limit period");
	blank_off_a: assert property (turn_on |-> off_gap >= BLANK_SHORT - 1)
		else $error("turn-on inside blanking");
	starter_gap_a: assert property (turn_on ##0 o_starter_mode |->
		on_gap >= STARTER_PERIOD - 2)
		else $error("starter turn-on early");
	limit_off_a: assert property (o_gate && i_cmp.current_limit |-> ##[1:10] !o_gate)
		else $error("no turn-off after limit");
	trig_delay_a: assert property (turn_on ##0 !o_starter_mode |->
		trig_age >= TRIG_DELAY + 2 && trig_age <= TRIG_DELAY + 9)
		else $error("valley turn-on not after trigger delay");
endmodule

// >>> tb/vsc_far_model.sv
// winding and current-sense comparator model facing the switch
`timescale 1ns/1ps
module vsc_far #(
	parameter int DM = 20 // demag plateau, cycles
) (
	input wire logic i_clk_sys, // clock
	input wire logic i_gate, // switch on
	input wire logic i_ring, // winding can arm
	input wire logic i_strobe_hi, // plateau above 1 V
	input wire logic [15:0] i_ton, // cycles to limit
	input wire logic [15:0] i_half, // half ring period
	output logic o_arm_above, // above arming level
	output logic o_trig_below, // below trigger level
	output logic o_strobe_hi, // above 1 V
	output logic o_current_limit // current at limit
);
	logic g_q = 1'b0;
	int t = 0;
	logic hi;
	// cycles since the switch last changed state
	always @(posedge i_clk_sys) begin
		g_q <= i_gate;
		t <= (i_gate != g_q) ? 1 : t + 1;
	end
	// plateau then endless ringing; on-time pulls the winding low
	assign hi = !g_q && i_ring && (t < DM || ((t - DM) / i_half) % 2 == 1);
	assign o_arm_above = hi;
	assign o_trig_below = !hi;
	assign o_strobe_hi = hi && i_strobe_hi;
	assign o_current_limit = g_q && t >= i_ton;
endmodule

// >>> tb/valley_switch_turn_on_control_tb.sv
// self-checking bench for the valley-switched turn-on control
`timescale 1ns/1ps
module valley_switch_turn_on_control_tb;
	import vsc_pkg::*;
	localparam int TD = 5;
	localparam int BS = 60;
	localparam int SP = 300;
	localparam int DM = 20;
	localparam int OSC = OSC_LOW_CYC;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic son = 1'b0;
	logic slo = 1'b0;
	logic iok = 1'b1;
	logic trip = 1'b0;
	logic ring = 1'b0;
	logic st = 1'b0;
	logic [15:0] ton = 16'h0014;
	logic [15:0] half = 16'h0008;
	logic f_arm, f_trig, f_st, f_ilim, gate, rc, smode, blong, flt;
	logic h_arm, h_trig, h_st, h_ilim, gate_h;
	logic gh_q = 1'b0;
	vsc_cmp_t cmp;
	vsc_cmp_t cmp_h;
	int h_last = 0;
	int h_gap = 99999;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int rises[$];
	int r, f, m, p, k, hp, seen;
	// comparator levels gathered for the design
	assign cmp = '{f_arm, f_trig, f_st, son, slo, iok, trip, f_ilim};
	assign cmp_h = '{h_arm, h_trig, h_st, son, slo, iok, trip, h_ilim};
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	vsc_turn_on_ctrl #(.STARTER_PERIOD(SP), .TRIG_DELAY(TD), .STROBE_AT(10),
		.BLANK_SHORT(BS), .BLANK_LONG(100)) dut_u (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_cmp(cmp), .o_gate(gate), .o_reduced_charge(rc), .o_starter_mode(smode),
		.o_blank_long(blong), .o_fault(flt));
	vsc_far #(.DM(DM)) far_u (.i_clk_sys(clk), .i_gate(gate), .i_ring(ring),
		.i_strobe_hi(st), .i_ton(ton), .i_half(half), .o_arm_above(f_arm),
		.o_trig_below(f_trig), .o_strobe_hi(f_st), .o_current_limit(f_ilim));
	// faster variant on the same stimulus, judged on its closest turn-ons
	vsc_turn_on_ctrl #(.HIGH_FREQ(1'b1), .STARTER_PERIOD(SP), .TRIG_DELAY(TD), .STROBE_AT(10),
		.BLANK_SHORT(BS), .BLANK_LONG(100)) dut_hf_u (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_cmp(cmp_h), .o_gate(gate_h), .o_reduced_charge(), .o_starter_mode(),
		.o_blank_long(), .o_fault());
	vsc_far #(.DM(DM)) far_hf_u (.i_clk_sys(clk), .i_gate(gate_h), .i_ring(ring),
		.i_strobe_hi(st), .i_ton(ton), .i_half(half), .o_arm_above(h_arm),
		.o_trig_below(h_trig), .o_strobe_hi(h_st), .o_current_limit(h_ilim));
	// closest on-to-on spacing of the faster variant, seen off the edge
	always @(negedge clk) begin
		gh_q <= gate_h;
		if (gate_h && !gh_q) begin
			h_last <= cyc;
			if (h_last > 0 && cyc - h_last < h_gap) begin
				h_gap <= cyc - h_last;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	// bounded wait for a gate level; t is the cycle it was seen
	task wait_gate(input logic lvl, output int t);
		seen = 0;
		for (int i = 0; i < 4000 && seen == 0; i++) begin
			@(negedge clk);
			seen = int'(gate === lvl);
		end
		chk("gate_level", 1, seen);
		t = cyc;
	endtask
	task cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk_rst;
		chk("reset_outs", 5'h06, {gate, rc, smode, blong, flt});
	endtask
	// a valley turn-on lands a fixed delay after its trigger
	function automatic logic in_win(input int x);
		return x >= TD + 2 && x <= TD + 9;
	endfunction
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog against a hung wait
	initial begin
		#(40 * 40000);
		failures++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		void'($urandom(89));
		repeat (20) @(posedge clk);
		chk_rst();
		rst_n <= 1'b1;
		@(negedge clk);
		chk_rst();
		@(posedge clk) son <= 1'b1;
		wait_gate(1, r);
		wait_gate(0, f);
		wait_gate(1, m);
		chk("starter_gap", 1, m - r >= SP - 1 && m - r <= SP + 3);
		chk("blank_long", 1, blong);
		@(posedge clk) ring <= 1'b1;
		st <= 1'b1;
		rises.push_back(m);
		// valley model: armed after blanking, trigger after limit period
		for (int i = 0; i < 14; i++) begin
			hp = 7 + $urandom % 7;
			@(posedge clk);
			half <= hp[15:0];
			ton <= ($urandom % 2) ? 16'h0096 : 16'h0014;
			r = rises[$];
			wait_gate(0, f);
			wait_gate(1, m);
			rises.push_back(m);
			p = f + DM;
			k = 0;
			while (k == 0 || p + 6 < r + OSC || p - hp + 6 < f + BS) begin
				p += 2 * hp;
				k++;
			end
			if (i > 1)
				chk("valley_on", 1, in_win(m - p) || (in_win(m - p - 2 * hp) &&
					(p < r + OSC || p - hp < f + BS)));
		end
		chk("starter_mode", 0, smode);
		chk("hf_min_gap", 1, h_gap >= OSC_HIGH_CYC && h_gap < OSC_LOW_CYC);
		chk("blank_long", 0, blong);
		@(posedge clk) ring <= 1'b0;
		cycles(600);
		chk("starter_back", 1, smode);
		@(posedge clk) trip <= 1'b1;
		cycles(6);
		chk("trip_outs", 2'h1, {gate, flt});
		@(posedge clk) trip <= 1'b0;
		son <= 1'b0;
		slo <= 1'b1;
		iok <= 1'b0;
		cycles(6);
		chk("charge_no_input", 0, rc);
		@(posedge clk) slo <= 1'b0;
		iok <= 1'b1;
		@(posedge clk) slo <= 1'b1;
		cycles(6);
		chk("charge_on", 1, rc);
		@(posedge clk) slo <= 1'b0;
		son <= 1'b1;
		cycles(6);
		chk("restart_outs", 4'h3, {flt, rc, smode, blong});
		wait_gate(1, m);
		@(posedge clk) rst_n <= 1'b0;
		cycles(3);
		chk_rst();
		@(posedge clk) rst_n <= 1'b1;
		// outputs must keep their reset values before and after the first rising edge after release
		cycles(1);
		chk_rst();
		cycles(1);
		chk_rst();
		tally_and_finish();
	end
endmodule
bind vsc_turn_on_ctrl vsc_turn_on_ctrl_asserts #(.HIGH_FREQ(HIGH_FREQ),
	.STARTER_PERIOD(STARTER_PERIOD), .TRIG_DELAY(TRIG_DELAY), .BLANK_SHORT(BLANK_SHORT))
	chk_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cmp(i_cmp), .o_gate(o_gate),
	.o_reduced_charge(o_reduced_charge), .o_starter_mode(o_starter_mode),
	.o_blank_long(o_blank_long), .o_fault(o_fault));
